// >>> logic/flash_cmd_pkg.sv
// Constants, register map and carrier types for the serial flash command controller
package flash_cmd_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_COUNTS  = 12'h000;
  localparam logic [11:0] OFS_CTRL    = 12'h004;
  localparam logic [11:0] OFS_WDATA   = 12'h008;
  localparam logic [11:0] OFS_STATUS  = 12'h024;
  localparam logic [11:0] OFS_CRC     = 12'h028;
  localparam logic [3:0]  BUF_PAGE    = 4'h4;

  // Reset values and CRC polynomial
  localparam logic [31:0] COUNTS_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0400;
  localparam logic [31:0] WDATA_RST   = 32'h0000_0000;
  localparam logic [31:0] CRC_INIT    = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY    = 32'hEDB8_8320;

  // Field positions
  localparam int RCNT_LSB  = 8;
  localparam int RCNT_MSB  = 31;
  localparam int WCNT_MSB  = 2;
  localparam int B2_LSB    = 24;
  localparam int B1_LSB    = 16;
  localparam int CAP_LSB   = 11;
  localparam int CAP_MSB   = 13;
  localparam int XFER_BIT  = 10;
  localparam int INFO_BIT  = 9;
  localparam int PP_BIT    = 8;
  localparam int TRG_BIT   = 0;
  localparam int ST_ERR    = 0;
  localparam int ST_LONG   = 1;
  localparam int ST_CRCEN  = 2;
  localparam int ST_BUSY   = 3;

  // Limits and fixed values
  localparam logic [24:0] BUF_BYTES   = 25'h000_0100;
  localparam logic [7:0]  PAD_BYTE    = 8'hFF;
  localparam logic [7:0]  READ_FILL   = 8'h00;
  localparam logic [23:0] INFO_OFFSET = 24'h00_1000;
  localparam logic [23:0] INFO_MASK   = 24'hFF_F000;

  // Capacity codes and their address masks
  localparam logic [2:0]  CAP_2M      = 3'b001;
  localparam logic [2:0]  CAP_512K    = 3'b010;
  localparam logic [2:0]  CAP_256K    = 3'b100;
  localparam logic [2:0]  CAP_128K    = 3'b101;
  localparam logic [23:0] MASK_2M     = 24'h1F_FFFF;
  localparam logic [23:0] MASK_512K   = 24'h07_FFFF;
  localparam logic [23:0] MASK_256K   = 24'h03_FFFF;
  localparam logic [23:0] MASK_128K   = 24'h01_FFFF;

  // Serial clock: sys_clk cycles per half period of the flash clock
  localparam logic [3:0]  SCLK_HALF   = 4'h2;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } spi_out_t;

  typedef struct packed {
    logic [23:0] addr;
    logic        err;
  } guard_t;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_CHECK = 3'b001,
    SEQ_LOAD  = 3'b010,
    SEQ_XFER  = 3'b011,
    SEQ_DONE  = 3'b100
  } seq_state_t;

endpackage

// >>> logic/info_area_guard.sv
// Address offset and info-area wraparound check for address-carrying commands
`timescale 1ns/1ps
module info_area_guard (
  input  wire logic [7:0]             addr_hi,     // Second write byte
  input  wire logic [7:0]             addr_mid,    // Third write byte
  input  wire logic [7:0]             addr_lo,     // Fourth write byte
  input  wire logic                   info_en,     // Info-area access allowed
  input  wire logic                   addr_xfer,   // Bytes two..four are an address
  input  wire logic [2:0]             capacity,    // Flash capacity code
  output flash_cmd_pkg::guard_t       result       // Corrected address and error
);
  logic [23:0] raw_addr;
  logic        offset_en;
  logic [23:0] corr_addr;
  logic [23:0] cap_mask;
  logic        cap_known;

  assign raw_addr  = {addr_hi, addr_mid, addr_lo};
  assign offset_en = addr_xfer & ~info_en; // [R11] [R14] [R16]
  // Carry out of bit 4 of the third byte ripples into the second byte
  assign corr_addr = offset_en ? raw_addr + flash_cmd_pkg::INFO_OFFSET : raw_addr; // [R9] [R10] [R15]

  assign cap_known = (capacity == flash_cmd_pkg::CAP_2M)   || (capacity == flash_cmd_pkg::CAP_512K) ||
                     (capacity == flash_cmd_pkg::CAP_256K) || (capacity == flash_cmd_pkg::CAP_128K); // [R6]
  assign cap_mask  = (capacity == flash_cmd_pkg::CAP_2M)   ? flash_cmd_pkg::MASK_2M   :
                     (capacity == flash_cmd_pkg::CAP_512K) ? flash_cmd_pkg::MASK_512K :
                     (capacity == flash_cmd_pkg::CAP_256K) ? flash_cmd_pkg::MASK_256K :
                     flash_cmd_pkg::MASK_128K; // [R6]

  logic        wrap_err;
  // Unknown and unassigned codes get the offset only, no wrap check
  assign wrap_err = offset_en & cap_known &
                    ((corr_addr & cap_mask & flash_cmd_pkg::INFO_MASK) == 24'h00_0000); // [R7] [R8] [R20]
  // One driver for the whole carrier
  assign result   = '{addr: corr_addr, err: wrap_err};
endmodule // info_area_guard

// >>> logic/serial_flash_cmd_control.sv
// Serial flash command sequencer with APB registers and info-area protection
//
// How it works
// [R1] Read bytes land in the buffer; read count in bits 31:8, at most 256 buffered.
// [R2] With CRC checking on, read count may reach 16M bytes.
// [R3] Write count in bits 2:0 is 1..7; bytes sent from write fields in order.
// [R4] A seventh write byte is sent as FF.
// [R5] Software puts the opcode in control bits 23:16, second byte in 31:24.
// [R6] Capacity code 13:11: 001 2MB, 010 512KB, 100 256KB, 101 128KB.
// [R7] Code 000 applies only the 4KB offset, no wraparound blocking.
// [R8] Known capacity: address modulo capacity in lowest 4KB is an error.
// [R9] Address flag set: bytes two..four form an address sent plus 0x1000.
// [R10] Address flag clear: bytes two..four are sent unchanged.
// [R11] Offset applied only with info access clear and address flag set.
// [R12] Software clears address flag or sets info access before status writes.
// [R13] Software sets the address flag once at setup and leaves it.
// [R14] Info access set: the first 4KB may be read, programmed, erased.
// [R15] Info clear, address set: info erase hits 4KB..8KB instead.
// [R16] Both bits clear: info area fully accessible.
// [R17] Blocked access sets error flag, returns to idle, clears trigger.
// [R18] Trigger written one starts a command; hardware clears it when done.
// [R19] After a blocked access software clears the long-operation bit.
// [R20] Unassigned capacity codes behave like the unknown code.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module serial_flash_cmd_control (
  input  wire logic                     sys_clk,   // 125 MHz system clock
  input  wire logic                     resetn,    // Synchronous reset, active low
  input  wire logic                     psel,      // APB select
  input  wire logic                     penable,   // APB enable
  input  wire logic                     pwrite,    // APB write
  input  wire logic [11:0]              paddr,     // APB byte address
  input  wire logic [31:0]              pwdata,    // APB write data
  output logic      [31:0]              prdata,    // APB read data
  output logic                          pready,    // APB ready
  output logic                          pslverr,   // APB error, unmapped address
  output flash_cmd_pkg::spi_out_t       spi_out,   // Flash clock, select, data out
  input  wire logic                     spi_miso   // Flash data in, asynchronous
);
  // Registers
  logic [31:0]                 counts_r;
  logic [31:0]                 ctrl_r;
  logic [31:0]                 wdata_r;
  logic                        err_r;
  logic                        long_op_r;
  logic                        crc_en_r;
  logic [31:0]                 crc_r;
  logic [31:0]                 buf_mem [0:63];
  logic [31:0]                 prdata_r;
  logic                        pslverr_r;

  // Sequencer state
  flash_cmd_pkg::seq_state_t   state_r;
  flash_cmd_pkg::guard_t       guard;
  logic [23:0]                 addr_r;
  logic [24:0]                 byte_idx_r;
  logic [2:0]                  bit_cnt_r;
  logic [7:0]                  tx_r;
  logic [7:0]                  rx_r;
  logic [3:0]                  div_r;
  logic                        sclk_r;
  logic                        cs_n_r;
  logic                        miso_meta_r;
  logic                        miso_sync_r;

  // Bus decode
  wire        setup_ph  = psel & ~penable;
  wire        wr_acc    = psel & penable & pwrite;
  wire        hit_cnt   = paddr == flash_cmd_pkg::OFS_COUNTS;
  wire        hit_ctrl  = paddr == flash_cmd_pkg::OFS_CTRL;
  wire        hit_wdata = paddr == flash_cmd_pkg::OFS_WDATA;
  wire        hit_stat  = paddr == flash_cmd_pkg::OFS_STATUS;
  wire        hit_crc   = paddr == flash_cmd_pkg::OFS_CRC;
  wire        hit_buf   = (paddr[11:8] == flash_cmd_pkg::BUF_PAGE) && (paddr[1:0] == 2'b00);
  wire        mapped    = hit_cnt | hit_ctrl | hit_wdata | hit_stat | hit_crc | hit_buf;
  wire [5:0]  buf_word  = paddr[7:2];

  // Field views
  wire [2:0]  wcount    = counts_r[flash_cmd_pkg::WCNT_MSB:0];
  wire [23:0] rcount    = counts_r[flash_cmd_pkg::RCNT_MSB:flash_cmd_pkg::RCNT_LSB];
  wire [2:0]  capacity  = ctrl_r[flash_cmd_pkg::CAP_MSB:flash_cmd_pkg::CAP_LSB];
  wire        addr_xfer = ctrl_r[flash_cmd_pkg::XFER_BIT];
  wire        info_en   = ctrl_r[flash_cmd_pkg::INFO_BIT];
  wire        trigger   = ctrl_r[flash_cmd_pkg::TRG_BIT];
  wire        busy      = state_r != flash_cmd_pkg::SEQ_IDLE;

  // Buffered reads stop at the buffer size unless CRC checking is on
  wire [24:0] rcount_eff = (!crc_en_r && ({1'b0, rcount} > flash_cmd_pkg::BUF_BYTES)) ?
                           flash_cmd_pkg::BUF_BYTES : {1'b0, rcount}; // [R1] [R2]
  wire [24:0] total_bytes = rcount_eff + {22'h00_0000, wcount};

  // Sequencer decode
  wire        tick       = div_r == flash_cmd_pkg::SCLK_HALF - 4'h1;
  wire        fall_tick  = tick & sclk_r;
  wire        byte_end   = fall_tick & (bit_cnt_r == 3'h7);
  wire        in_read    = byte_idx_r >= {22'h00_0000, wcount};
  wire [24:0] rd_idx     = byte_idx_r - {22'h00_0000, wcount};
  wire        store_rd   = (state_r == flash_cmd_pkg::SEQ_XFER) & byte_end & in_read &
                           (rd_idx < flash_cmd_pkg::BUF_BYTES); // [R1]
  wire [7:0]  rx_byte    = {rx_r[6:0], miso_sync_r};
  wire [24:0] next_idx   = byte_idx_r + 25'h000_0001;
  wire        last_byte  = next_idx >= total_bytes;
  wire        seq_done   = state_r == flash_cmd_pkg::SEQ_DONE;
  wire        seq_block  = (state_r == flash_cmd_pkg::SEQ_CHECK) & guard.err;

  // Outgoing byte selection; address bytes come from the guarded value
  logic [7:0] tx_sel;
  always_comb begin
    case (byte_idx_r[2:0])
      3'h0:    tx_sel = ctrl_r[flash_cmd_pkg::B1_LSB +: 8]; // [R3] [R5]
      3'h1:    tx_sel = addr_r[23:16]; // [R3] [R9] [R10]
      3'h2:    tx_sel = addr_r[15:8]; // [R11]
      3'h3:    tx_sel = addr_r[7:0];
      3'h4:    tx_sel = wdata_r[23:16];
      3'h5:    tx_sel = wdata_r[31:24];
      3'h6:    tx_sel = flash_cmd_pkg::PAD_BYTE; // [R4]
      default: tx_sel = flash_cmd_pkg::PAD_BYTE;
    endcase
  end
  wire [7:0] tx_next = in_read ? flash_cmd_pkg::READ_FILL : tx_sel;

  info_area_guard u_guard (
    .addr_hi   (ctrl_r[flash_cmd_pkg::B2_LSB +: 8]),
    .addr_mid  (wdata_r[7:0]),
    .addr_lo   (wdata_r[15:8]),
    .info_en   (info_en),
    .addr_xfer (addr_xfer),
    .capacity  (capacity),
    .result    (guard)
  );

  // CRC32, reflected, one byte at a time
  function automatic logic [31:0] crc_byte(input logic [31:0] crc_in, input logic [7:0] data);
    logic [31:0] c;
    c = crc_in ^ {24'h00_0000, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ flash_cmd_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // Read mux
  wire [31:0] status_rd = {28'h000_0000, busy, crc_en_r, long_op_r, err_r};
  wire [31:0] rd_mux = hit_cnt   ? counts_r :
                       hit_ctrl  ? ctrl_r :
                       hit_wdata ? wdata_r :
                       hit_stat  ? status_rd :
                       hit_crc   ? ~crc_r :
                       hit_buf   ? buf_mem[buf_word] : 32'h0000_0000;

  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign spi_out = '{sclk: sclk_r, cs_n: cs_n_r, mosi: tx_r[7]};

  // APB answer, captured in the setup phase so it stands through the access
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= ~mapped;
    end
  end

  // Miso synchroniser
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      miso_meta_r <= 1'b0;
      miso_sync_r <= 1'b0;
    end else begin
      miso_meta_r <= spi_miso;
      miso_sync_r <= miso_meta_r;
    end
  end

  // Count and data registers; writes while busy are accepted, software must not
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      counts_r <= flash_cmd_pkg::COUNTS_RST;
      wdata_r  <= flash_cmd_pkg::WDATA_RST;
      crc_en_r <= 1'b0;
    end else if (wr_acc) begin
      if (hit_cnt) counts_r <= pwdata & 32'hFFFF_FF07;
      if (hit_wdata) wdata_r <= pwdata;
      if (hit_stat) crc_en_r <= pwdata[flash_cmd_pkg::ST_CRCEN];
    end
  end

  // Control register: trigger and page-program bits cleared by hardware
  logic [31:0] ctrl_nxt;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (seq_done) begin
      ctrl_nxt[flash_cmd_pkg::TRG_BIT] = 1'b0; // [R18]
      ctrl_nxt[flash_cmd_pkg::PP_BIT]  = 1'b0;
    end
    if (seq_block) begin
      ctrl_nxt[flash_cmd_pkg::TRG_BIT] = 1'b0; // [R17]
    end
    // A software write lands after the hardware clear, so a new trigger wins
    if (wr_acc && hit_ctrl) begin
      ctrl_nxt = pwdata & 32'hFFFF_3F01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_r <= flash_cmd_pkg::CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Error flag (write one to clear, set wins) and long-operation bit
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      err_r     <= 1'b0;
      long_op_r <= 1'b0;
    end else begin
      if (seq_block) begin
        err_r <= 1'b1; // [R17]
      end else if (wr_acc && hit_stat && pwdata[flash_cmd_pkg::ST_ERR]) begin
        err_r <= 1'b0;
      end
      // Blocked path leaves this bit set; software clears it
      if (wr_acc && hit_stat) begin
        long_op_r <= pwdata[flash_cmd_pkg::ST_LONG]; // [R19]
      end else if (seq_done) begin
        long_op_r <= 1'b0;
      end
    end
  end

  // Read buffer: hardware fills it, software may also write it
  always_ff @(posedge sys_clk) begin
    if (store_rd) begin
      buf_mem[rd_idx[7:2]][{rd_idx[1:0], 3'b000} +: 8] <= rx_byte; // [R1]
    end else if (wr_acc && hit_buf) begin
      buf_mem[buf_word] <= pwdata;
    end
  end

  // Serial clock divider, runs only during a transfer
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div_r <= 4'h0;
    end else if (state_r != flash_cmd_pkg::SEQ_XFER || tick) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // Command sequencer
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r    <= flash_cmd_pkg::SEQ_IDLE;
      addr_r     <= 24'h00_0000;
      byte_idx_r <= 25'h000_0000;
      bit_cnt_r  <= 3'h0;
      tx_r       <= 8'h00;
      rx_r       <= 8'h00;
      sclk_r     <= 1'b0;
      cs_n_r     <= 1'b1;
      crc_r      <= flash_cmd_pkg::CRC_INIT;
    end else begin
      case (state_r)
        flash_cmd_pkg::SEQ_IDLE: begin
          if (trigger) begin
            state_r <= flash_cmd_pkg::SEQ_CHECK; // [R18]
          end
        end
        flash_cmd_pkg::SEQ_CHECK: begin
          addr_r     <= guard.addr;
          byte_idx_r <= 25'h000_0000;
          crc_r      <= flash_cmd_pkg::CRC_INIT;
          if (guard.err) begin
            state_r <= flash_cmd_pkg::SEQ_IDLE; // [R8] [R17]
          end else if (total_bytes == 25'h000_0000) begin
            state_r <= flash_cmd_pkg::SEQ_DONE;
          end else begin
            state_r <= flash_cmd_pkg::SEQ_LOAD; // [R14] [R16]
          end
        end
        flash_cmd_pkg::SEQ_LOAD: begin
          cs_n_r    <= 1'b0;
          tx_r      <= tx_next; // [R3]
          bit_cnt_r <= 3'h0;
          state_r   <= flash_cmd_pkg::SEQ_XFER;
        end
        flash_cmd_pkg::SEQ_XFER: begin
          if (tick) begin
            sclk_r <= ~sclk_r;
          end
          // Sample on the falling edge: the sync delay keeps the rising-edge value
          if (fall_tick) begin
            rx_r      <= rx_byte;
            tx_r      <= {tx_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 3'h1;
          end
          if (byte_end) begin
            if (in_read) begin
              crc_r <= crc_byte(crc_r, rx_byte); // [R2]
            end
            byte_idx_r <= next_idx;
            if (last_byte) begin
              state_r <= flash_cmd_pkg::SEQ_DONE;
            end else begin
              state_r <= flash_cmd_pkg::SEQ_LOAD;
            end
          end
        end
        flash_cmd_pkg::SEQ_DONE: begin
          cs_n_r  <= 1'b1;
          sclk_r  <= 1'b0;
          state_r <= flash_cmd_pkg::SEQ_IDLE; // [R18]
        end
        default: begin
          state_r <= flash_cmd_pkg::SEQ_IDLE;
        end
      endcase
    end
  end
endmodule // serial_flash_cmd_control

// >>> tb/serial_flash_cmd_control_props.sv
// Concurrent checks on the flash command controller ports
`timescale 1ns/1ps
module serial_flash_cmd_control_props (
  input wire logic                    sys_clk,  // Clock
  input wire logic                    resetn,   // Reset, active low
  input wire logic                    psel,     // APB select
  input wire logic                    penable,  // APB enable
  input wire logic                    pwrite,   // APB write
  input wire logic [11:0]             paddr,    // APB address
  input wire logic [31:0]             pwdata,   // APB write data
  input wire logic [31:0]             prdata,   // APB read data
  input wire logic                    pready,   // APB ready
  input wire logic                    pslverr,  // APB error
  input wire flash_cmd_pkg::spi_out_t spi_out,  // Flash pins
  input wire logic                    spi_miso  // Flash data in
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [15:0] wd_r;
  logic [2:0]  wcnt_r, rise_r, cap_w;
  logic        op7_r, sclk_d_r, cs_d_r, wr_w, trig_w, blk_w, go_w, map_w;
  logic [23:0] msk_w, cor_w;
  assign wr_w = psel && penable && pwrite;
  assign cap_w = pwdata[13:11];
  assign cor_w = {pwdata[31:24], wd_r[7:0], wd_r[15:8]} + 24'h00_1000;
  assign msk_w = cap_w == 3'h1 ? 24'h1F_FFFF : cap_w == 3'h2 ? 24'h07_FFFF :
                 cap_w == 3'h4 ? 24'h03_FFFF : cap_w == 3'h5 ? 24'h01_FFFF : 24'h00_0000;
  assign trig_w = wr_w && paddr == flash_cmd_pkg::OFS_CTRL && pwdata[0];
  assign blk_w = trig_w && pwdata[10] && !pwdata[9] && msk_w != 24'h0 && (cor_w & msk_w) < 24'h00_1000;
  assign go_w = trig_w && !blk_w && wcnt_r != 3'h0;
  assign map_w = paddr inside {12'h000, 12'h004, 12'h008, 12'h024, 12'h028} || paddr[11:8] == 4'h4;
  // Bits of a frame counted mod 8 from sclk rises
  always_ff @(posedge sys_clk) begin
    if (wr_w && paddr == flash_cmd_pkg::OFS_WDATA) wd_r <= pwdata[15:0];
    if (wr_w && paddr == flash_cmd_pkg::OFS_COUNTS) wcnt_r <= pwdata[2:0];
    if (wr_w && paddr == flash_cmd_pkg::OFS_CTRL) op7_r <= pwdata[23];
    sclk_d_r <= spi_out.sclk;
    cs_d_r <= spi_out.cs_n;
    rise_r <= (spi_out.cs_n && cs_d_r) ? 3'h0 : rise_r + 3'(spi_out.sclk && !sclk_d_r);
  end
  sequence s_sclk_pulse;
    spi_out.sclk [*2] ##1 !spi_out.sclk;
  endsequence
  a_blocked_stays_idle: assert property (blk_w |=> spi_out.cs_n [*8])
    else $error("flash selected after a blocked command");
  a_trigger_starts_frame: assert property (go_w |-> ##[1:6] !spi_out.cs_n)
    else $error("command did not select the flash");
  a_unmapped_error: assert property (psel && penable && !map_w |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_no_error: assert property (psel && penable && map_w |-> !pslverr)
    else $error("mapped access flagged as error");
  a_sclk_half_period: assert property ($rose(spi_out.sclk) |-> s_sclk_pulse)
    else $error("serial clock high phase wrong");
  a_sclk_idle_low: assert property (spi_out.cs_n |-> !spi_out.sclk)
    else $error("serial clock active while deselected");
  a_mosi_hold: assert property (spi_out.sclk |-> $stable(spi_out.mosi))
    else $error("data out changed while clock high");
  a_opcode_first: assert property ($fell(spi_out.cs_n) |-> spi_out.mosi == op7_r)
    else $error("first bit is not opcode bit 7");
  a_whole_bytes: assert property ($rose(spi_out.cs_n) |-> rise_r == 3'h0)
    else $error("frame ended inside a byte");
  a_ctrl_reserved: assert property (psel && penable && !pwrite && paddr == flash_cmd_pkg::OFS_CTRL
                                    |-> prdata[15:14] == 2'h0 && prdata[7:1] == 7'h00)
    else $error("reserved control bits read nonzero");
endmodule // serial_flash_cmd_control_props

bind serial_flash_cmd_control serial_flash_cmd_control_props serial_flash_cmd_control_props_i (
  .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .spi_out(spi_out), .spi_miso(spi_miso));

// >>> tb/flash_partner.sv
// Behavioural serial flash: records bytes, answers a fixed pattern
`timescale 1ns/1ps
module flash_partner (
  input wire logic sclk,  // Serial clock
  input wire logic cs_n,  // Select, active low
  input wire logic mosi,  // Data from controller
  output logic     miso   // Data to controller
);
  logic [7:0] sh_r;
  logic [7:0] rx_q[$];
  int         nbit;
  int         nbyte;
  function automatic logic pbit(int n, int b);
    logic [7:0] p;
    p = 8'(n) ^ 8'h5A;
    return p[7 - b];
  endfunction
  initial miso = 1'b0;
  always @(negedge cs_n) begin
    nbit = 0;
    nbyte = 0;
    miso = pbit(0, 0);
  end
  // Released line shows the inverse, not a stale copy
  always @(posedge cs_n) miso <= #10 ~miso;
  always @(posedge sclk) if (!cs_n) begin
    sh_r = {sh_r[6:0], mosi};
    nbit++;
    if (nbit == 8) begin
      rx_q.push_back(sh_r);
      nbit = 0;
      nbyte++;
    end
  end
  // Output valid delay after the falling edge
  always @(negedge sclk) if (!cs_n) miso <= #10 pbit(nbyte, nbit);
endmodule // flash_partner

// >>> tb/serial_flash_cmd_control_bench.sv
// Self-checking bench: registers, command frames, info-area guard
`timescale 1ns/1ps
module serial_flash_cmd_control_bench;
  logic                    sys_clk, resetn, psel, penable, pwrite, pready, pslverr, spi_miso, e;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, q;
  flash_cmd_pkg::spi_out_t spi_out;
  int                      num_errors, n_checks, seed;

  serial_flash_cmd_control serial_flash_cmd_control_i (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi_out(spi_out), .spi_miso(spi_miso));
  flash_partner flash_partner_i (.sclk(spi_out.sclk), .cs_n(spi_out.cs_n), .mosi(spi_out.mosi), .miso(spi_miso));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] pat(int n);
    return 8'(n) ^ 8'h5A;
  endfunction

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_cmd(int wc, int rc, logic [2:0] cap, logic xfer, logic info, logic crc, logic [23:0] adr);
    logic [7:0]  op;
    logic [7:0]  b[7];
    logic [23:0] a2, msk;
    logic [31:0] cr;
    logic        blk;
    int          nrd, n;
    op = 8'($random(seed));
    a2 = (xfer && !info) ? adr + 24'h00_1000 : adr;
    case (cap)
      3'h1: msk = 24'h1F_FFFF;
      3'h2: msk = 24'h07_FFFF;
      3'h4: msk = 24'h03_FFFF;
      3'h5: msk = 24'h01_FFFF;
      default: msk = 24'h00_0000;
    endcase
    blk = xfer && !info && msk != 24'h0 && (a2 & msk) < 24'h00_1000;
    nrd = (rc > 256 && !crc) ? 256 : rc;
    b = '{op, a2[23:16], a2[15:8], a2[7:0], 8'h55, 8'h66, 8'hFF};
    apb(1'b1, flash_cmd_pkg::OFS_STATUS, {29'h0, crc, 2'h1});
    apb(1'b1, flash_cmd_pkg::OFS_COUNTS, {24'(rc), 5'h00, 3'(wc)});
    apb(1'b1, flash_cmd_pkg::OFS_WDATA, {16'h6655, adr[7:0], adr[15:8]});
    flash_partner_i.rx_q.delete();
    apb(1'b1, flash_cmd_pkg::OFS_CTRL, {adr[23:16], op, 2'h0, cap, xfer, info, 9'h001});
    n = 0;
    do begin
      apb(1'b0, flash_cmd_pkg::OFS_CTRL, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 5000);
    check("trigger", 32'h0, {31'h0, q[0]});
    apb(1'b0, flash_cmd_pkg::OFS_STATUS, 32'h0);
    check("error flag", {31'h0, blk}, {31'h0, q[0]});
    check("frame bytes", 32'(blk ? 0 : wc + nrd), 32'(flash_partner_i.rx_q.size()));
    for (int i = 0; i < flash_partner_i.rx_q.size(); i++)
      check("sent byte", 32'((i < wc) ? b[i] : 8'h00), 32'(flash_partner_i.rx_q[i]));
    if (!blk && nrd >= 4) begin
      apb(1'b0, 12'h400, 32'h0);
      check("buffer word", {pat(wc + 3), pat(wc + 2), pat(wc + 1), pat(wc)}, q);
    end
    if (!blk && crc) begin
      cr = flash_cmd_pkg::CRC_INIT;
      for (int i = 0; i < nrd; i++) begin
        cr = cr ^ {24'h00_0000, pat(wc + i)};
        repeat (8) cr = cr[0] ? ((cr >> 1) ^ flash_cmd_pkg::CRC_POLY) : (cr >> 1);
      end
      apb(1'b0, flash_cmd_pkg::OFS_CRC, 32'h0);
      check("crc result", ~cr, q);
    end
    if (blk) begin
      apb(1'b1, flash_cmd_pkg::OFS_STATUS, 32'h0000_0001);
      apb(1'b0, flash_cmd_pkg::OFS_STATUS, 32'h0);
      check("status cleared", 32'h0, {30'h0, q[1:0]});
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    report_and_stop;
  end

  initial begin
    seed = 70180;
    num_errors = 0;
    n_checks = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(1'b0, flash_cmd_pkg::OFS_COUNTS, 32'h0);
    check("counts reset", 32'h0000_0000, q);
    apb(1'b0, flash_cmd_pkg::OFS_CTRL, 32'h0);
    check("control reset", 32'h0000_0400, q);
    apb(1'b1, flash_cmd_pkg::OFS_CTRL, 32'hFFFF_FFFE);
    apb(1'b0, flash_cmd_pkg::OFS_CTRL, 32'h0);
    check("control fields", 32'hFFFF_3F00, q);
    apb(1'b1, 12'h0F0, 32'hFFFF_FFFF);
    apb(1'b0, 12'h0F0, 32'h0);
    check("unmapped error", 32'h1, {31'h0, e});
    run_cmd(7, 260, 3'h0, 1'b0, 1'b0, 1'b0, 24'h12_3456);
    run_cmd(2, 300, 3'h1, 1'b1, 1'b0, 1'b1, 24'h00_2000);
    run_cmd(4, 0, 3'h0, 1'b1, 1'b0, 1'b0, 24'h00_0000);
    for (int c = 0; c < 8; c++) begin
      run_cmd(c % 7 + 1, 4, 3'(c), 1'b1, 1'b0, 1'b0, 24'h1F_F800);
      run_cmd(4, 0, 3'(c), 1'b1, 1'b1, 1'b0, 24'h00_0100);
    end
    repeat (12) begin
      q = $random(seed);
      run_cmd(q[2:0] % 7 + 1, q[5:3], q[8:6], q[9], q[10], 1'b0, {q[23:21], q[11] ? 9'h1FF : q[20:12], q[31:24], q[15:12]});
    end
    report_and_stop;
  end
endmodule // serial_flash_cmd_control_bench
